// ===== core/input_filter.v
// Sampled three-flop input filter for one control input.
// Assumes sampleTick is a one-cycle enable pulse on clk.
`timescale 1ns/1ps
module input_filter
(
  // Clock and reset
  input  wire clk,
  input  wire rst_b,
  // Sampling
  input  wire sampleTick,
  input  wire pinIn,
  output reg  level
);
  reg syncA;
  reg syncB;
  reg syncC;

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      syncC <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      syncA <= pinIn;
      syncB <= syncA;
      syncC <= syncB;
      // Agreement only counts at the read cycle
      if (sampleTick && (syncB == syncC))
        level <= syncC;
    end
  end
endmodule

// ===== core/servo_stop_sequence_select.v
// Stop-sequence selection and input sampling for a linear servo drive.
// Assumes a plain register port master and external pin level inputs.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "stop_select_defines.vh"
module servo_stop_sequence_select
#(
  parameter HOLD_UNIT_CYCLES = `CYCLES_PER_MS,
  parameter READ_CNT0        = `READ_CYC0_CNT,
  parameter READ_CNT1        = `READ_CYC1_CNT,
  parameter READ_CNT2        = `READ_CYC2_CNT,
  parameter READ_CNT3        = `READ_CYC3_CNT
)
(
  // Clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // Power-up strobe, marks power off then on
  input  wire        powerCycle,
  // Register port
  input  wire [3:0]  regAddr,
  input  wire [15:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [15:0] regRdata,
  // Drive status from the power stage
  input  wire        servoOnReq,
  input  wire        mainPowerOk,
  input  wire        alarmActive,
  input  wire        alarmIsImmStop,
  input  wire        motorStopped,
  input  wire [8:0]  loadPercent,
  input  wire [15:0] travelExcess,
  // Control input pin
  input  wire        alarmClearPin,
  // Stop actions
  output reg         dynBrake,
  output reg         freeRun,
  output reg         immStop,
  output reg         servoFree,
  output reg         errCntClear,
  output reg  [8:0]  forceLimit,
  output reg         undervoltageTrip,
  output reg         servoOffByPower,
  output reg         alarmClear,
  output reg         irq
);
  // Action codes
  localparam ACT_NONE = 2'd0;
  localparam ACT_DB   = 2'd1;
  localparam ACT_FREE = 2'd2;
  localparam ACT_IMM  = 2'd3;

  reg [3:0]  srvOffSel;
  reg [3:0]  mainOffSel;
  reg        uvSel;
  reg [10:0] holdTimeSet;
  reg [10:0] holdTimeAct;
  reg [3:0]  alarmSel;
  reg [8:0]  immForce;
  reg [8:0]  ovlLevel;
  reg [9:0]  ovrunLimit;
  reg [1:0]  readSelSet;
  reg [1:0]  readSelAct;
  reg        almRstSel;
  reg [`ST_WIDTH-1:0] status;
  reg [`ST_WIDTH-1:0] irqMask;

  // Register writes; powerCycle latches deferred settings
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      srvOffSel   <= `RST_STOP_SEL;
      mainOffSel  <= `RST_STOP_SEL;
      uvSel       <= `RST_UV_SEL;
      holdTimeSet <= `RST_HOLD_TIME;
      holdTimeAct <= `RST_HOLD_TIME;
      alarmSel    <= `RST_STOP_SEL;
      immForce    <= `RST_FORCE;
      ovlLevel    <= `RST_FORCE;
      ovrunLimit  <= `RST_OVRUN_LIMIT;
      readSelSet  <= `RST_READ_CYC;
      readSelAct  <= `RST_READ_CYC;
      almRstSel   <= `RST_ALM_RST;
      irqMask     <= {`ST_WIDTH{1'b0}};
    end
    else
    begin
      if (powerCycle)
      begin
        holdTimeAct <= holdTimeSet;
        readSelAct  <= readSelSet;
      end
      if (regWr)
      begin
        case (regAddr)
          `OFS_SRVOFF_SEL:   srvOffSel   <= regWdata[3:0];
          `OFS_MAINOFF_SEL:  mainOffSel  <= regWdata[3:0];
          `OFS_UV_SEL:       uvSel       <= regWdata[0];
          `OFS_HOLD_TIME:    holdTimeSet <= regWdata[10:0];
          `OFS_ALARM_SEL:    alarmSel    <= regWdata[3:0];
          `OFS_ISTOP_FORCE:  immForce    <= regWdata[8:0];
          `OFS_OVL_LEVEL:    ovlLevel    <= regWdata[8:0];
          `OFS_OVRUN_LIMIT:  ovrunLimit  <= regWdata[9:0];
          `OFS_READ_CYC_SEL: readSelSet  <= regWdata[1:0];
          `OFS_ALM_RST_SEL:  almRstSel   <= regWdata[0];
          `OFS_IRQ_MASK:     irqMask     <= regWdata[`ST_WIDTH-1:0];
          default:           irqMask     <= irqMask;
        endcase
      end
    end
  end

  // Range checks fall back to defaults
  wire [3:0] srvCode  = (srvOffSel > `MAX_STOP_SEL) ?
                        `RST_STOP_SEL : srvOffSel;
  wire [3:0] mainCode = (mainOffSel > `MAX_STOP_SEL) ?
                        `RST_STOP_SEL : mainOffSel;
  wire [3:0] almCode  = (alarmSel > `MAX_ALARM_SEL) ?
                        `RST_STOP_SEL : alarmSel;
  wire [10:0] holdMs  = (holdTimeAct < `MIN_HOLD_TIME ||
                         holdTimeAct > `MAX_HOLD_TIME) ?
                        `RST_HOLD_TIME : holdTimeAct;
  wire [8:0] immLim   = (immForce > `MAX_PERCENT) ? `RST_FORCE : immForce;
  wire [8:0] ovlLim   = (ovlLevel > `MAX_PERCENT) ? `RST_FORCE : ovlLevel;
  wire [9:0] ovrLim   = (ovrunLimit > `MAX_OVRUN_LIMIT) ?
                        `RST_OVRUN_LIMIT : ovrunLimit;

  // Read cycle divider
  reg  [19:0] readCnt;
  reg  [19:0] readTop;
  wire        readTick = (readCnt == 20'h0_0000);

  always @*
  begin
    case (readSelAct)
      2'd0:    readTop = READ_CNT0[19:0] - 20'h0_0001;
      2'd1:    readTop = READ_CNT1[19:0] - 20'h0_0001;
      2'd2:    readTop = READ_CNT2[19:0] - 20'h0_0001;
      default: readTop = READ_CNT3[19:0] - 20'h0_0001;
    endcase
  end

  always @(posedge clk)
  begin
    if (!rst_b)
      readCnt <= 20'h0_0000;
    else if (readTick)
      readCnt <= readTop;
    else
      readCnt <= readCnt - 20'h0_0001;
  end

  // Millisecond tick
  reg  [17:0] msCnt;
  wire        msTick = (msCnt == 18'h0_0000);
  always @(posedge clk)
  begin
    if (!rst_b || msTick)
      msCnt <= HOLD_UNIT_CYCLES[17:0] - 18'h0_0001;
    else
      msCnt <= msCnt - 18'h0_0001;
  end

  // Alarm clear pin, sampled at the read cycle
  wire clrLevel;
  input_filter clrFilt
  (
    .clk        (clk),
    .rst_b      (rst_b),
    .sampleTick (readTick),
    .pinIn      (alarmClearPin),
    .level      (clrLevel)
  );

  // Alarm clear qualification; pulse once per press
  reg [6:0] clrMs;
  reg       clrDone;
  wire      clrQual = almRstSel ? 1'b1
                      : (clrMs >= `ALM_CLR_HOLD_MS);
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      clrMs      <= 7'd0;
      clrDone    <= 1'b0;
      alarmClear <= 1'b0;
    end
    else
    begin
      alarmClear <= 1'b0;
      if (!clrLevel)
      begin
        clrMs   <= 7'd0;
        clrDone <= 1'b0;
      end
      else
      begin
        if (msTick && clrMs < `ALM_CLR_HOLD_MS)
          clrMs <= clrMs + 7'd1;
        if (clrQual && !clrDone)
        begin
          alarmClear <= 1'b1;
          clrDone    <= 1'b1;
        end
      end
    end
  end

  // Main power loss timing in ms
  reg [10:0] lossMs;
  reg        mainLoss;
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      lossMs   <= 11'd0;
      mainLoss <= 1'b0;
    end
    else if (mainPowerOk)
    begin
      lossMs   <= 11'd0;
      mainLoss <= 1'b0;
    end
    else if (msTick && !mainLoss)
    begin
      lossMs <= lossMs + 11'd1;
      if (lossMs + 11'd1 >= holdMs)
        mainLoss <= 1'b1;
    end
  end

  // Monitors
  wire overload = (loadPercent > ovlLim);
  wire overrun  = (travelExcess > {6'd0, ovrLim});
  wire uvTrip   = mainLoss & uvSel;

  // Stop decision: alarm or undervoltage trip first, then main loss, then servo off
  reg [1:0] decelAct;
  reg [1:0] stopAct;
  reg       clearCnt;
  reg       stopping;
  always @*
  begin
    decelAct = ACT_NONE;
    stopAct  = ACT_NONE;
    clearCnt = 1'b0;
    stopping = 1'b0;
    if (alarmActive || uvTrip)
    begin
      stopping = 1'b1;
      clearCnt = 1'b1;
      decelAct = almCode[0] ? ACT_FREE : ACT_DB;
      stopAct  = almCode[1] ? ACT_FREE : ACT_DB;
      // Codes 6 and 7 both coast while decelerating for alarms that are not immediate-stop
      if (almCode == 4'd6)
        decelAct = ACT_FREE;
      if (almCode[2] && alarmIsImmStop)
        decelAct = ACT_IMM;
    end
    else if (mainLoss || !servoOnReq)
    begin
      stopping = 1'b1;
      if (mainLoss)
        stopCode(mainCode);
      else
        stopCode(srvCode);
    end
  end

  // Shared decoding of servo-off style codes
  task stopCode;
    input [3:0] code;
    begin
      if (code >= 4'd8)
      begin
        decelAct = ACT_IMM;
        stopAct  = code[0] ? ACT_FREE : ACT_DB;
        clearCnt = 1'b1;
      end
      else
      begin
        decelAct = code[0] ? ACT_FREE : ACT_DB;
        stopAct  = code[1] ? ACT_FREE : ACT_DB;
        clearCnt = !code[2];
      end
    end
  endtask

  wire [1:0] act = motorStopped ? stopAct : decelAct;

  // Registered exclusive outputs
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      dynBrake         <= 1'b0;
      freeRun          <= 1'b0;
      immStop          <= 1'b0;
      servoFree        <= 1'b0;
      errCntClear      <= 1'b0;
      forceLimit       <= `RST_FORCE;
      undervoltageTrip <= 1'b0;
      servoOffByPower  <= 1'b0;
    end
    else
    begin
      dynBrake    <= stopping && act == ACT_DB;
      freeRun     <= stopping && !motorStopped && act == ACT_FREE;
      servoFree   <= stopping && motorStopped && act == ACT_FREE;
      immStop     <= stopping && act == ACT_IMM;
      errCntClear <= stopping && clearCnt;
      forceLimit  <= (stopping && act == ACT_IMM) ? immLim
                     : `MAX_PERCENT;
      undervoltageTrip <= uvTrip;
      servoOffByPower  <= mainLoss & ~uvSel;
    end
  end

  // Sticky status, write one to clear; a set wins
  wire [`ST_WIDTH-1:0] events;
  assign events[`ST_MAINLOSS] = mainLoss;
  assign events[`ST_UVTRIP]   = uvTrip;
  assign events[`ST_OVERLOAD] = overload;
  assign events[`ST_OVERRUN]  = overrun;
  assign events[`ST_ALMCLR]   = alarmClear;

  genvar i;
  generate
    for (i = 0; i < `ST_WIDTH; i = i + 1)
    begin : stickyBits
      always @(posedge clk)
      begin
        if (!rst_b)
          status[i] <= 1'b0;
        else if (events[i])
          status[i] <= 1'b1;
        else if (regWr && regAddr == `OFS_STATUS && regWdata[i])
          status[i] <= 1'b0;
      end
    end
  endgenerate

  always @(posedge clk)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |(status & irqMask);
  end

  // Read data, one cycle after the strobe
  always @(posedge clk)
  begin
    if (!rst_b)
      regRdata <= 16'h0000;
    else if (regRd)
    begin
      case (regAddr)
        `OFS_SRVOFF_SEL:   regRdata <= {12'h000, srvOffSel};
        `OFS_MAINOFF_SEL:  regRdata <= {12'h000, mainOffSel};
        `OFS_UV_SEL:       regRdata <= {15'h0000, uvSel};
        `OFS_HOLD_TIME:    regRdata <= {5'h00, holdTimeSet};
        `OFS_ALARM_SEL:    regRdata <= {12'h000, alarmSel};
        `OFS_ISTOP_FORCE:  regRdata <= {7'h00, immForce};
        `OFS_OVL_LEVEL:    regRdata <= {7'h00, ovlLevel};
        `OFS_OVRUN_LIMIT:  regRdata <= {6'h00, ovrunLimit};
        `OFS_READ_CYC_SEL: regRdata <= {14'h0000, readSelSet};
        `OFS_ALM_RST_SEL:  regRdata <= {15'h0000, almRstSel};
        `OFS_STATUS:       regRdata <= {11'h000, status};
        `OFS_IRQ_MASK:     regRdata <= {11'h000, irqMask};
        `OFS_STATE:        regRdata <= {9'h000, clrLevel, immStop,
                                        servoFree, freeRun, dynBrake,
                                        mainLoss, overload};
        default:           regRdata <= 16'h0000;
      endcase
    end
    else
      regRdata <= 16'h0000;
  end
endmodule

// ===== core/stop_select_defines.vh
// Constants for the stop-sequence selection block.
// Assumes a 200 MHz clock; times are given in ns or ms with derived counts.
`ifndef STOP_SELECT_DEFINES_VH
`define STOP_SELECT_DEFINES_VH

`define CLK_PERIOD_NS      5
`define CYCLES_PER_MS      (1000000 / `CLK_PERIOD_NS)
// Input read cycles in ns
`define READ_CYC0_NS       166000
`define READ_CYC1_NS       333000
`define READ_CYC2_NS       1000000
`define READ_CYC3_NS       1666000
`define READ_CYC0_CNT      (`READ_CYC0_NS / `CLK_PERIOD_NS)
`define READ_CYC1_CNT      (`READ_CYC1_NS / `CLK_PERIOD_NS)
`define READ_CYC2_CNT      (`READ_CYC2_NS / `CLK_PERIOD_NS)
`define READ_CYC3_CNT      (`READ_CYC3_NS / `CLK_PERIOD_NS)
`define ALM_CLR_HOLD_MS    120
// Register offsets
`define OFS_SRVOFF_SEL     4'h0
`define OFS_MAINOFF_SEL    4'h1
`define OFS_UV_SEL         4'h2
`define OFS_HOLD_TIME      4'h3
`define OFS_ALARM_SEL      4'h4
`define OFS_ISTOP_FORCE    4'h5
`define OFS_OVL_LEVEL      4'h6
`define OFS_OVRUN_LIMIT    4'h7
`define OFS_READ_CYC_SEL   4'h8
`define OFS_ALM_RST_SEL    4'h9
`define OFS_STATUS         4'hA
`define OFS_IRQ_MASK       4'hB
`define OFS_STATE          4'hC
// Reset values
`define RST_STOP_SEL       4'h0
`define RST_UV_SEL         1'b1
`define RST_HOLD_TIME      11'd70
`define RST_FORCE          9'd0
`define RST_OVRUN_LIMIT    10'd10
`define RST_READ_CYC       2'h0
`define RST_ALM_RST        1'b0
// Limits
`define MAX_STOP_SEL       4'h9
`define MAX_ALARM_SEL      4'h7
`define MIN_HOLD_TIME      11'd70
`define MAX_HOLD_TIME      11'd2000
`define MAX_PERCENT        9'd500
`define MAX_OVRUN_LIMIT    10'd1000
// Status bit positions
`define ST_MAINLOSS        0
`define ST_UVTRIP          1
`define ST_OVERLOAD        2
`define ST_OVERRUN         3
`define ST_ALMCLR          4
`define ST_WIDTH           5

`endif

// ===== tb/alarm_clear_host.sv
// Host-side model that presses the alarm clear input.
// Assumes go is a one-cycle request on clk.
`timescale 1ns/1ps
module alarm_clear_host
(
  // Clock
  input  wire        clk,
  // Request
  input  wire        go,
  input  wire [15:0] holdCycles,
  // Control input pin
  output logic       pin
);
  logic [15:0] left;

  initial
  begin
    pin = 1'b0;
    left = 16'h0000;
  end

  // Pin stays high for the whole requested time, low otherwise
  always @(posedge clk)
  begin
    if (go)
      left <= holdCycles;
    else if (left != 16'h0000)
      left <= left - 16'h0001;
    pin <= go || (left > 16'h0001);
  end
endmodule

// ===== tb/servo_stop_sequence_select_sva.sv
// Checker for stop actions, loss detection and alarm clear.
// Assumes one clock; sees the block's ports only.
`timescale 1ns/1ps
module servo_stop_sequence_select_sva
(
  // Clock and reset
  input logic       clk,
  input logic       rst_b,
  // Drive status
  input logic       servoOnReq,
  input logic       mainPowerOk,
  input logic       alarmActive,
  input logic       alarmIsImmStop,
  input logic       motorStopped,
  input logic       alarmClearPin,
  // Stop actions
  input logic       dynBrake,
  input logic       freeRun,
  input logic       immStop,
  input logic       servoFree,
  input logic [8:0] forceLimit,
  input logic       undervoltageTrip,
  input logic       servoOffByPower,
  input logic       alarmClear
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_stop_onehot: assert property (
    $onehot0({dynBrake, freeRun, immStop, servoFree}))
    else $error("stop outputs overlap");
  a_force_idle: assert property (
    $past(rst_b) && !immStop |-> forceLimit == 9'h1f4)
    else $error("force limit not full outside immediate stop");
  a_stopped_no_imm: assert property (
    $past(motorStopped) |-> !immStop)
    else $error("immediate stop after motor stopped");
  a_alarm_no_imm: assert property (
    $past(alarmActive && !alarmIsImmStop) |-> !immStop)
    else $error("immediate stop for plain alarm");
  a_servo_on_idle: assert property (
    $past(servoOnReq && !alarmActive) && $past(mainPowerOk, 2) &&
    !$past(undervoltageTrip) && !$past(servoOffByPower) &&
    !undervoltageTrip && !servoOffByPower
    |-> !(dynBrake || freeRun || immStop || servoFree))
    else $error("stop action while servo on");
  a_loss_wait: assert property (
    $fell(mainPowerOk) && !servoOffByPower |=> !servoOffByPower [*8])
    else $error("power loss flagged too early");
  a_trip_excl: assert property (
    !(undervoltageTrip && servoOffByPower))
    else $error("trip and servo off together");
  a_clear_pulse: assert property (
    alarmClear |=> !alarmClear)
    else $error("alarm clear longer than one cycle");
  a_clear_pin: assert property (
    alarmClear |-> $past(alarmClearPin, 3))
    else $error("alarm clear without held pin");
endmodule

bind servo_stop_sequence_select servo_stop_sequence_select_sva u_sva
(
  .clk(clk), .rst_b(rst_b), .servoOnReq(servoOnReq),
  .mainPowerOk(mainPowerOk), .alarmActive(alarmActive),
  .alarmIsImmStop(alarmIsImmStop), .motorStopped(motorStopped),
  .alarmClearPin(alarmClearPin), .dynBrake(dynBrake),
  .freeRun(freeRun), .immStop(immStop), .servoFree(servoFree),
  .forceLimit(forceLimit), .undervoltageTrip(undervoltageTrip),
  .servoOffByPower(servoOffByPower), .alarmClear(alarmClear)
);

// ===== tb/servo_stop_sequence_select_tb_top.sv
// Self-checking bench for the stop-sequence selection block.
// Assumes 200 MHz clock and ms ticks scaled to 10 cycles.
`timescale 1ns/1ps
module servo_stop_sequence_select_tb_top;
  logic        clk, rst_b, powerCycle, regWr, regRd, go;
  logic [3:0]  regAddr, c, mc;
  logic [15:0] regWdata, regRdata, travelExcess, holdCycles, e;
  logic        servoOnReq, mainPowerOk, alarmActive, alarmIsImmStop;
  logic        motorStopped, alarmClearPin, dynBrake, freeRun, immStop;
  logic        servoFree, errCntClear, undervoltageTrip, servoOffByPower;
  logic        alarmClear, irq, al, im;
  logic [8:0]  loadPercent, forceLimit, frc, lvl;
  logic [15:0] stopOut;
  int          errorCnt, checkCount, cycles, clrCount, seed, i, n;

  assign stopOut = {12'h000, dynBrake, freeRun, immStop, servoFree};

  servo_stop_sequence_select #(.HOLD_UNIT_CYCLES(10), .READ_CNT0(4),
    .READ_CNT1(8), .READ_CNT2(16), .READ_CNT3(24)) u_dut
  (
    .clk(clk), .rst_b(rst_b), .powerCycle(powerCycle),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .servoOnReq(servoOnReq),
    .mainPowerOk(mainPowerOk), .alarmActive(alarmActive),
    .alarmIsImmStop(alarmIsImmStop), .motorStopped(motorStopped),
    .loadPercent(loadPercent), .travelExcess(travelExcess),
    .alarmClearPin(alarmClearPin), .dynBrake(dynBrake),
    .freeRun(freeRun), .immStop(immStop), .servoFree(servoFree),
    .errCntClear(errCntClear), .forceLimit(forceLimit),
    .undervoltageTrip(undervoltageTrip),
    .servoOffByPower(servoOffByPower), .alarmClear(alarmClear),
    .irq(irq)
  );

  alarm_clear_host u_host
  (
    .clk(clk), .go(go), .holdCycles(holdCycles), .pin(alarmClearPin)
  );

  // Stop action expected for a code, {brake, coast, immediate, free}
  function automatic logic [15:0] expStop(input logic [3:0] k0,
    input logic a, input logic m, input logic st);
    logic [3:0] k;
    k = (k0 > (a ? 4'h7 : 4'h9)) ? 4'h0 : k0;
    if (!st && (a ? (k[2] && m) : k[3]))
      return 16'h0002;
    if (st)
      return ((a || !k[3]) ? k[1] : k[0]) ? 16'h0001 : 16'h0008;
    return (k[0] || (a && k == 4'h6)) ? 16'h0004 : 16'h0008;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [15:0] x);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdata, x);
  endtask

  // Loss must show near the 70 ms default even after a new hold time
  task automatic waitLoss(input logic uv);
    @(posedge clk);
    mainPowerOk <= 1'b0;
    n = 0;
    #1;
    while ((uv ? undervoltageTrip : servoOffByPower) !== 1'b1 && n < 900)
    begin
      #5;
      n++;
    end
    chk(16'(n >= 685 && n <= 720), 16'h0001);
    chk(16'(uv ? servoOffByPower : undervoltageTrip), 16'h0000);
  endtask

  task automatic press(input logic [15:0] h, input int x);
    n = clrCount;
    @(posedge clk);
    go <= 1'b1;
    holdCycles <= h;
    @(posedge clk);
    go <= 1'b0;
    // Wait past the whole press plus filter lag before counting
    repeat (int'(h) + 250) @(posedge clk);
    #1 chk(16'(clrCount - n), 16'(x));
  endtask

  task automatic completeRun;
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cycle ceiling well above the expected few thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (alarmClear === 1'b1)
      clrCount++;
    if (cycles == 8000)
    begin
      errorCnt++;
      completeRun;
    end
  end

  initial
  begin
    seed = 32'hf4d9_9549;
    {rst_b, powerCycle, regWr, regRd, go, alarmActive} = 6'h00;
    {alarmIsImmStop, motorStopped} = 2'h0;
    {servoOnReq, mainPowerOk} = 2'h3;
    {regAddr, regWdata, holdCycles} = 36'h0_0000_0000;
    loadPercent = 9'h000;
    travelExcess = 16'h0000;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 10; i++)
      rdChk(i[3:0], i == 2 ? 16'h0001 : i == 3 ? 16'h0046 :
        i == 7 ? 16'h000a : 16'h0000);
    rdChk(4'hd, 16'h0000);
    frc = 9'($unsigned($random(seed)) % 501);
    wr(4'h5, {7'h00, frc});
    // Codes 10 and 11, and alarm codes above 7, act as the default
    for (i = 0; i < 24; i++)
    begin
      c = 4'(i % 12);
      al = i >= 12;
      im = 1'($random(seed));
      wr(al ? 4'h4 : 4'h0, {12'h000, c});
      @(posedge clk);
      alarmActive <= al;
      alarmIsImmStop <= im;
      servoOnReq <= 1'b0;
      motorStopped <= 1'b0;
      repeat (2) @(posedge clk);
      e = expStop(c, al, im, 1'b0);
      #1 chk(stopOut, e);
      if (!al) chk(16'(errCntClear), 16'(!(c >= 4 && c <= 7)));
      if (e[1]) chk(16'(forceLimit), 16'(frc));
      @(posedge clk);
      motorStopped <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk(stopOut, expStop(c, al, im, 1'b1));
      @(posedge clk);
      servoOnReq <= 1'b1;
      alarmActive <= 1'b0;
    end
    mc = 4'($unsigned($random(seed)) % 10);
    wr(4'h1, {12'h000, mc});
    wr(4'h2, 16'h0000);
    wr(4'h3, 16'h00c8);
    waitLoss(1'b0);
    chk(stopOut, expStop(mc, 1'b0, 1'b0, 1'b1));
    @(posedge clk);
    mainPowerOk <= 1'b1;
    wr(4'h2, 16'h0001);
    repeat (4) @(posedge clk);
    waitLoss(1'b1);
    rdChk(4'ha, 16'h0003);
    @(posedge clk);
    mainPowerOk <= 1'b1;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    lvl = 9'($unsigned($random(seed)) % 400 + 1);
    wr(4'h6, {7'h00, lvl});
    wr(4'hb, 16'h000c);
    @(posedge clk);
    loadPercent <= lvl;
    travelExcess <= 16'h000a;
    repeat (3) @(posedge clk);
    rdChk(4'ha, 16'h0000);
    chk(16'(irq), 16'h0000);
    @(posedge clk);
    loadPercent <= lvl + 9'h001;
    travelExcess <= 16'h000b;
    repeat (3) @(posedge clk);
    rdChk(4'ha, 16'h000c);
    chk(16'(irq), 16'h0001);
    wr(4'hb, 16'h0000);
    repeat (2) @(posedge clk);
    #1 chk(16'(irq), 16'h0000);
    @(posedge clk);
    loadPercent <= lvl;
    travelExcess <= 16'h000a;
    wr(4'hb, 16'h000c);
    wr(4'ha, 16'h000c);
    rdChk(4'ha, 16'h0000);
    chk(16'(irq), 16'h0000);
    wr(4'h8, 16'h0003);
    @(posedge clk);
    powerCycle <= 1'b1;
    @(posedge clk);
    powerCycle <= 1'b0;
    wr(4'h9, 16'h0001);
    press(16'h0096, 1);
    rdChk(4'ha, 16'h0010);
    wr(4'h9, 16'h0000);
    press(16'h00c8, 0);
    // Held past 120 ms, so code 0 must accept it once
    press(16'h0514, 1);
    completeRun;
  end
endmodule
